// ### logic/return_and_rotate_exec.v
`timescale 1ns/1ps
`include "ret_rot_defines.vh"

// Behaviour
// RQ1: subroutine exit pops stack into program counter; no flag changes.
// RQ2: subroutine exit takes two cycles; next fetch from return address.
// RQ3: exit-with-literal loads 8-bit literal into working register, flags kept.
// RQ4: exit-with-literal also pops return address into PC; two cycles.
// RQ5: rotate-left shifts register left through carry, updates carry.
// RQ6: rotate-left select 0 writes working register, 1 writes source back.
// RQ7: rotate-right shifts register right through carry, updates carry.
// RQ8: rotate-right select 0 writes working register, 1 writes source back.
// RQ9: left: carry gets bit 7, bit 0 old carry; right mirrored; one cycle.
module return_and_rotate_exec #(
    parameter DATA_WIDTH = 8,
    parameter PC_WIDTH = 15,
    parameter ADDR_WIDTH = 7
) (
    // clock and reset
    input wire clk,
    input wire reset,
    // decoded instruction
    input wire instrValid,
    input wire [2:0] opCode,
    input wire [DATA_WIDTH-1:0] literal,
    input wire [ADDR_WIDTH-1:0] fileAddr,
    input wire destSel,
    // return stack
    input wire [PC_WIDTH-1:0] stackTopValue,
    output wire stackPop,
    // program counter
    output reg [PC_WIDTH-1:0] pcLoadValue,
    output reg pcLoad,
    // fetch control
    output wire busy,
    output reg flushFetch,
    // data memory
    input wire [DATA_WIDTH-1:0] fileRdData,
    output wire [ADDR_WIDTH-1:0] fileRdAddr,
    output reg fileWrEn,
    output reg [ADDR_WIDTH-1:0] fileWrAddr,
    output reg [DATA_WIDTH-1:0] fileWrData,
    // core state
    output wire [DATA_WIDTH-1:0] workReg,
    output wire carryFlag
);

    // =========================================================
    // states
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_SECOND = 2'b10;

    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [DATA_WIDTH-1:0] work_q;
    reg [DATA_WIDTH-1:0] work_d;
    reg carry_q;
    reg carry_d;
    reg popNow;

    wire [DATA_WIDTH-1:0] rotResult;
    wire rotCarry;
    wire accept;
    wire isRot;
    wire isExit;
    wire isLitExit;
    wire isLeft;
    wire rotToWork;
    wire rotToFile;

    // =========================================================
    // decode helpers
    function isExitOp;
        input [2:0] op;
        begin
            isExitOp = (op == `OP_SUB_EXIT) || (op == `OP_EXIT_LIT);
        end
    endfunction

    function isRotOp;
        input [2:0] op;
        begin
            isRotOp = (op == `OP_ROT_LEFT) || (op == `OP_ROT_RIGHT);
        end
    endfunction

    function isLeftOp;
        input [2:0] op;
        begin
            isLeftOp = (op == `OP_ROT_LEFT);
        end
    endfunction

    // =========================================================
    // request decode
    // requests count only while no exit is finishing
    assign accept = instrValid && (state_q == ST_IDLE); // RQ2
    assign isExit = accept && isExitOp(opCode);
    assign isLitExit = isExit && (opCode == `OP_EXIT_LIT); // RQ3
    assign isRot = accept && isRotOp(opCode);
    assign isLeft = isLeftOp(opCode); // RQ5
    assign rotToWork = isRot && (destSel == `DEST_WORK); // RQ6
    assign rotToFile = isRot && (destSel == `DEST_FILE); // RQ8

    // =========================================================
    // outputs
    assign fileRdAddr = fileAddr;
    assign workReg = work_q;
    assign carryFlag = carry_q;
    assign stackPop = popNow;
    // fetch stalls during the second exit cycle
    assign busy = (state_q == ST_SECOND); // RQ2

    // =========================================================
    // rotator
    rotate_unit #(
        .WIDTH(DATA_WIDTH)
    ) rotator (
        .source(fileRdData),
        .carryIn(carry_q),
        .rotLeft(isLeft),
        .result(rotResult),
        .carryOut(rotCarry)
    );

    // =========================================================
    // next state
    always @* begin
        state_d = state_q;
        work_d = work_q;
        carry_d = carry_q;
        popNow = 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (isExit) begin
                    popNow = 1'b1; // RQ1
                    state_d = ST_SECOND; // RQ2
                    if (isLitExit) begin
                        work_d = literal; // RQ3
                    end
                end else if (isRot) begin
                    carry_d = rotCarry; // RQ5 RQ7
                    if (rotToWork) begin
                        work_d = rotResult; // RQ6 RQ8
                    end
                end
            end
            ST_SECOND: begin
                state_d = ST_IDLE; // RQ4
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // =========================================================
    // core state registers
    always @(posedge clk) begin
        if (reset) begin
            state_q <= ST_IDLE;
            work_q <= `WORK_RESET;
            carry_q <= `CARRY_RESET;
        end else begin
            state_q <= state_d;
            work_q <= work_d;
            carry_q <= carry_d;
        end
    end

    // =========================================================
    // program counter reload
    always @(posedge clk) begin
        if (reset) begin
            pcLoad <= 1'b0;
            pcLoadValue <= {PC_WIDTH{1'b0}};
            flushFetch <= 1'b0;
        end else begin
            // popped value loads the program counter
            pcLoad <= popNow; // RQ1
            flushFetch <= popNow; // RQ2
            if (popNow) begin
                pcLoadValue <= stackTopValue; // RQ4
            end
        end
    end

    // =========================================================
    // write back strobe
    always @(posedge clk) begin
        if (reset) begin
            fileWrEn <= 1'b0;
        end else begin
            // result goes back to the source register
            fileWrEn <= rotToFile; // RQ6 RQ8
        end
    end

    // =========================================================
    // write back address and data
    always @(posedge clk) begin
        if (reset) begin
            fileWrAddr <= {ADDR_WIDTH{1'b0}};
            fileWrData <= {DATA_WIDTH{1'b0}};
        end else begin
            // held until the next accepted rotate
            if (isRot) begin
                fileWrAddr <= fileAddr;
                fileWrData <= rotResult; // RQ7
            end
        end
    end

endmodule

// ### logic/ret_rot_defines.vh
`ifndef RET_ROT_DEFINES_VH
`define RET_ROT_DEFINES_VH

// operation codes on the decoded operation port
`define OP_NONE 3'h0
`define OP_SUB_EXIT 3'h1
`define OP_EXIT_LIT 3'h2
`define OP_ROT_LEFT 3'h3
`define OP_ROT_RIGHT 3'h4

// destination select values
`define DEST_WORK 1'b0
`define DEST_FILE 1'b1

// reset values
`define WORK_RESET 8'h00
`define CARRY_RESET 1'b0

// cycle counts per instruction
`define EXIT_CYCLES 2
`define ROT_CYCLES 1

`endif

// ### logic/rotate_unit.v
`timescale 1ns/1ps
`include "ret_rot_defines.vh"

module rotate_unit #(
    parameter WIDTH = 8
) (
    // operands
    input wire [WIDTH-1:0] source,
    input wire carryIn,
    input wire rotLeft,
    // results
    output wire [WIDTH-1:0] result,
    output wire carryOut
);

    // nine-bit rotation through carry
    assign result = rotLeft ? {source[WIDTH-2:0], carryIn} // RQ9
                            : {carryIn, source[WIDTH-1:1]}; // RQ9
    assign carryOut = rotLeft ? source[WIDTH-1] : source[0]; // RQ9

endmodule

// ### testbench/ret_rot_assertions.sv
`timescale 1ns/1ps
// ==========
// checks
module ret_rot_checker(
    input wire clk, reset, instrValid, destSel, stackPop, pcLoad,
    input wire busy, flushFetch, fileWrEn, carryFlag,
    input wire [2:0] opCode,
    input wire [7:0] literal, fileRdData, fileWrData, workReg,
    input wire [14:0] stackTopValue, pcLoadValue
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire go = instrValid && !busy;
    wire ex = go && (opCode == 3'h1 || opCode == 3'h2);
    exit_pop_a: assert property (ex |-> stackPop)
        else $error("no pop");
    pc_restore_a: assert property (ex |=> pcLoad && $stable(carryFlag)
        && pcLoadValue == $past(stackTopValue)) else $error("bad pc");
    exit_gap_a: assert property (ex |=> busy && flushFetch ##1 !busy)
        else $error("bad gap");
    lit_load_a: assert property (go && opCode == 3'h2 |=>
        workReg == $past(literal)) else $error("bad literal");
    left_carry_a: assert property (go && opCode == 3'h3 |=>
        carryFlag == $past(fileRdData) >> 7) else $error("bad carry");
    right_carry_a: assert property (go && opCode == 3'h4 |=>
        carryFlag == ($past(fileRdData) & 8'h01)) else $error("bad carry");
    left_file_a: assert property (go && opCode == 3'h3 && destSel |=>
        fileWrEn && fileWrData == ($past(fileRdData) << 1 | $past(carryFlag)))
        else $error("bad write");
    right_work_a: assert property (go && opCode == 3'h4 && !destSel |=>
        !fileWrEn && workReg == ($past(fileRdData) >> 1 | $past(carryFlag) << 7))
        else $error("bad result");
endmodule
bind return_and_rotate_exec ret_rot_checker chk(.*);

// ### testbench/mem_model.sv
`timescale 1ns/1ps
// ==========
// data memory and return stack
module mem_model(
    input wire clk, stackPop, fileWrEn,
    input wire [6:0] fileRdAddr, fileWrAddr,
    input wire [7:0] fileWrData,
    output wire [7:0] fileRdData,
    output wire [14:0] stackTopValue
);
    reg [7:0] mem [0:127];
    reg [3:0] sp = 4'h0;
    integer i;
    initial for (i = 0; i < 128; i = i + 1) mem[i] = i * 8'h25;
    assign stackTopValue = {sp, 11'h2a5};
    assign fileRdData = mem[fileRdAddr];
    always @(posedge clk) begin
        sp <= sp - stackPop;
        if (fileWrEn) mem[fileWrAddr] <= fileWrData;
    end
endmodule

// ### testbench/tb_top.sv
`timescale 1ns/1ps
// ==========
// bench
module tb_top;
    reg clk = 1'b0, reset = 1'b1, instrValid = 1'b0, destSel = 1'b0;
    reg [2:0] opCode = 3'h0;
    reg [7:0] literal = 8'h00, w = 8'h00, v, r;
    reg [6:0] fileAddr = 7'h00;
    reg c = 1'b0, tk = 1'b0;
    reg [31:0] rnd = 32'h5b6626f5;
    reg [42:0] q [$];
    integer failures = 0, checksDone = 0, cyc = 0, n;
    wire stackPop, pcLoad, busy, flushFetch, fileWrEn, carryFlag;
    wire [7:0] fileRdData, fileWrData, workReg;
    wire [6:0] fileRdAddr, fileWrAddr;
    wire [14:0] stackTopValue, pcLoadValue;
    wire [42:0] seen = {pcLoad, flushFetch, busy, fileWrEn, carryFlag,
        workReg, pcLoad ? pcLoadValue : 15'h0000,
        fileWrEn ? {fileWrAddr, fileWrData} : 15'h0000};
    return_and_rotate_exec DUT(.*);
    mem_model m(.*);
    initial forever #5 clk = ~clk;
    task check(input [42:0] got, input [42:0] exp);
        begin
            checksDone = checksDone + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("MISMATCH %0t got %h want %h", $time, got, exp);
            end
        end
    endtask
    task finish_test;
        begin
            $display("checks %0d mismatches %0d", checksDone, failures);
            if (failures == 0 && checksDone > 0) $display("SIMULATION PASSED");
            else $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    task run_op(input [2:0] op);
        begin
            rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
            {instrValid, opCode, destSel, fileAddr} = {1'b1, op, rnd[15:8]};
            literal = rnd[7:0];
            v = m.mem[fileAddr];
            if (op == 3'h2) w = literal;
            if (op > 3'h2) begin
                r = (op == 3'h3) ? {v[6:0], c} : {c, v[7:1]};
                c = (op == 3'h3) ? v[7] : v[0];
                if (!destSel) w = r;
            end
            q.push_back({op < 3'h3, op < 3'h3, op < 3'h3,
                op > 3'h2 && destSel, c, w,
                (op < 3'h3) ? m.stackTopValue : 15'h0000,
                (op > 3'h2 && destSel) ? {fileAddr, r} : 15'h0000});
            @(posedge clk);
            #1;
            if (op < 3'h3) begin
                opCode = 3'h3;
                @(posedge clk);
                #1;
            end
        end
    endtask
    initial begin
        repeat (12) @(posedge clk);
        #1 reset = 1'b0;
        for (n = 0; n < 80; n = n + 1) run_op(rnd[18:16] % 3'h4 + 3'h1);
        instrValid = 1'b0;
        repeat (3) @(posedge clk);
        $display("random ops done");
        finish_test;
    end
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 1000) begin
            failures = failures + 1;
            finish_test;
        end else begin
            #2;
            if (tk) check(seen, q.pop_front());
            tk = instrValid && !busy && !reset;
        end
    end
endmodule
